// ===== core/trcal_defines.svh
/*
 Constants of the text row code and attribute logic: row buffer layout in
 the private memory, set codes, glyph limits and timing figures.
 Assumes inclusion by bare name from the package; both ends use it without including it.
*/
`ifndef TRCAL_DEFINES_SVH
`define TRCAL_DEFINES_SVH

// Row buffer layout
`define TRCAL_ROW_CODES 6'd40
`define TRCAL_LAST_CODE 6'd39
`define TRCAL_CBUF_BASE 8'h00
`define TRCAL_FILE_BASE 8'h28
`define TRCAL_FILE_LONGS 20
`define TRCAL_EXP_BASE 8'h80
`define TRCAL_SHORT_BYTES 80
`define TRCAL_MEM_WORDS 256

// Set type codes held in B[7:4]
`define TRCAL_SET_BASE 4'h0
`define TRCAL_SET_MOSAIC 4'h2
`define TRCAL_SET_STROKE 4'h3
`define TRCAL_SET_ACC_A 4'h4
`define TRCAL_SET_ACC_B 4'h5
`define TRCAL_SET_RAM_ALPHA 4'h8
`define TRCAL_SET_RAM_SEMI 4'ha
`define TRCAL_SET_RAM_STROKE 4'hb
`define TRCAL_SPACE_CODE 7'h20

// Glyph cells
`define TRCAL_LAST_SLICE 4'h9
`define TRCAL_DBL_LOW_OFS 4'h5
`define TRCAL_CELL_BYTES 10
`define TRCAL_LORES_CELL_BYTES 5
`define TRCAL_CELLS_PER_SET 100
`define TRCAL_LORES_CELLS 200
`define TRCAL_GLYPH_LOW_MAX 7'h03
`define TRCAL_GLYPH_HIGH_MIN 7'h20

// Timing
`define TRCAL_CLK_HZ 10000000
`define TRCAL_FLASH_PERIOD_MS 2000
`define TRCAL_FLASH_HALF_CYC \
   ((`TRCAL_FLASH_PERIOD_MS * (`TRCAL_CLK_HZ / 1000)) / 2)
`define TRCAL_SHIFT_DEN 2'd2

`endif

// ===== core/trcal_pkg.sv
/*
 Types shared by both ends: command codes and the state records.
 Assumes trcal_defines.svh on the include path.
*/
`include "trcal_defines.svh"

package trcal_pkg;
   typedef enum logic [2:0] {
      CMD_VAR, CMD_WIDEN, CMD_WACC, CMD_PACK,
      CMD_SHORT, CMD_LOAD, CMD_SLICE, CMD_NOP
   } trcal_op_t;

   typedef enum logic [1:0] {D_IDLE, D_ROW} trcal_dst_t;
   typedef enum logic [1:0] {H_IDLE, H_WAIT} trcal_hst_t;

   typedef struct packed {
      trcal_dst_t st;
      trcal_op_t op;
      logic [5:0] cptr;
      logic [7:0] fptr;
      logic [5:0] idx;
      logic [7:0] cur_b;
      logic [7:0] cur_a;
      logic [3:0] lat;
      logic busy;
      logic rsp_valid;
      logic [7:0] rsp_c;
      logic [7:0] rsp_b;
      logic [7:0] rsp_a;
      logic [23:0] flash_cnt;
      logic flash_ph;
      logic [1:0] div3;
      logic shift_en;
      logic [2:0] pix;
      logic m80_fg;
      logic m80_mosaic;
      logic [6:0] m80_glyph;
      logic [3:0] m80_attr;
      logic [14:0] gaddr;
      logic gwr;
      logic [14:0] gwr_addr;
      logic [7:0] gwr_data;
   } trcal_dev_t;

   typedef struct packed {
      trcal_hst_t st;
      logic cmd_valid;
      trcal_op_t op;
      logic rd;
      logic [5:0] x;
      logic [7:0] c;
      logic [7:0] b;
      logic [7:0] a;
      logic again;
      logic ready;
      logic done;
      logic err;
      logic [7:0] rc;
      logic [7:0] rb;
      logic [7:0] ra;
   } trcal_host_t;
endpackage : trcal_pkg

// ===== core/trcal_if.sv
/*
 Command link between the host end and the display code end.
 Assumes both ends on the same clock; the host holds cmd_valid one cycle.
*/
`timescale 1ns/1ps
`default_nettype none

interface trcal_if;
   import trcal_pkg::*;
   logic cmd_valid;
   trcal_op_t cmd_op;
   logic cmd_rd;
   logic [5:0] cmd_x;
   logic [7:0] cmd_c;
   logic [7:0] cmd_b;
   logic [7:0] cmd_a;
   logic busy;
   logic rsp_valid;
   logic [7:0] rsp_c;
   logic [7:0] rsp_b;
   logic [7:0] rsp_a;

   modport dev (
      input cmd_valid, cmd_op, cmd_rd, cmd_x, cmd_c, cmd_b, cmd_a,
      output busy, rsp_valid, rsp_c, rsp_b, rsp_a
   );
   modport hst (
      output cmd_valid, cmd_op, cmd_rd, cmd_x, cmd_c, cmd_b, cmd_a,
      input busy, rsp_valid, rsp_c, rsp_b, rsp_a
   );
endinterface : trcal_if

`default_nettype wire

// ===== core/trcal_dev.sv
/*
 Display code end: row buffers in private memory, variable, expanded and
 short code commands, glyph slice addressing, attribute rendering,
 pixel shift enable and 80-column code decode.
 Assumes one clock, render inputs synchronous to it, and a host that waits
 for rsp_valid before the next command.
*/
`timescale 1ns/1ps
`default_nettype none

module trcal_dev
   import trcal_pkg::*;
#(
   parameter int FLASH_HALF = `TRCAL_FLASH_HALF_CYC
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Command link
   trcal_if.dev bus,
   // Glyph fetch
   input wire logic [3:0] tv_line_i,
   input wire logic dbl_h_i,
   input wire logic dbl_low_i,
   input wire logic lores_i,
   input wire logic [7:0] glyph_c_i,
   input wire logic [7:0] glyph_b_i,
   input wire logic [7:0] set_origin_reg_i,
   output logic [14:0] glyph_addr_o,
   output logic glyph_wr_o,
   output logic [14:0] glyph_wr_addr_o,
   output logic [7:0] glyph_wr_data_o,
   // Pixel render
   input wire logic slice_bit_i,
   input wire logic [2:0] fg_i,
   input wire logic [2:0] bg_i,
   input wire logic ul_i,
   input wire logic flash_i,
   input wire logic conceal_i,
   input wire logic neg_i,
   input wire logic cur_ul_i,
   input wire logic cur_cpl_i,
   input wire logic ins_black_i,
   output logic [2:0] pixel_o,
   output logic shift_en_o,
   // 80-column decode
   input wire logic [7:0] code80_c_i,
   input wire logic [3:0] code80_a_i,
   input wire logic [2:0] col80_i,
   input wire logic [3:0] line80_i,
   output logic m80_fg_o,
   output logic m80_mosaic_o,
   output logic [6:0] m80_glyph_o,
   output logic [3:0] m80_attr_o
);
   logic [7:0] mem [0:`TRCAL_MEM_WORDS-1];
   trcal_dev_t s_r, s_nxt;
   logic [2:0] we;
   logic [2:0][7:0] wa;
   logic [2:0][7:0] wd;

   function automatic logic [7:0] exp_addr(input logic [5:0] i);
      exp_addr = 8'(`TRCAL_EXP_BASE + 8'(i) * 8'd3);
   endfunction : exp_addr

   function automatic logic is_acc(input logic [7:0] b);
      is_acc = (b[7:4] == `TRCAL_SET_ACC_A) ||
               (b[7:4] == `TRCAL_SET_ACC_B);
   endfunction : is_acc

   always_comb begin
      logic [5:0] cp;
      logic [7:0] fp;
      logic [7:0] rc, rb, ra, ea;
      logic lng, fgs;
      logic [2:0] f, g, pcol;
      logic [3:0] sl, blk;
      logic [9:0] mbits;
      logic [3:0] midx;
      cp = '0;
      fp = '0;
      rc = '0;
      rb = '0;
      ra = '0;
      ea = '0;
      lng = 1'b0;
      fgs = 1'b0;
      f = '0;
      g = '0;
      pcol = '0;
      sl = '0;
      blk = '0;
      mbits = '0;
      midx = '0;
      s_nxt = s_r;
      we = '0;
      wa = '0;
      wd = '0;
      s_nxt.rsp_valid = 1'b0;
      s_nxt.gwr = 1'b0;
      case (s_r.st)
         D_IDLE: begin
            if (bus.cmd_valid) begin
               s_nxt.rsp_valid = 1'b1;
               s_nxt.op = bus.cmd_op;
               cp = (bus.cmd_x == 6'd0) ? 6'd0 : s_r.cptr;
               fp = (bus.cmd_x == 6'd0) ? `TRCAL_FILE_BASE : s_r.fptr;
               case (bus.cmd_op)
                  CMD_VAR: begin
                     rc = bus.cmd_rd ? mem[8'(cp)] : bus.cmd_c;
                     if (bus.cmd_rd) begin
                        s_nxt.rsp_c = rc;
                        // Short codes carry no file bytes
                        s_nxt.rsp_b = rc[7] ? mem[fp] : 8'h00;
                        s_nxt.rsp_a = rc[7] ? mem[8'(fp + 8'd1)] : 8'h00;
                     end else begin
                        we[0] = 1'b1;
                        wa[0] = 8'(cp);
                        wd[0] = bus.cmd_c;
                        we[1] = rc[7];
                        wa[1] = fp;
                        wd[1] = bus.cmd_b;
                        we[2] = rc[7];
                        wa[2] = 8'(fp + 8'd1);
                        wd[2] = bus.cmd_a;
                     end
                     s_nxt.cptr = 6'(cp + 6'd1);
                     // Only long codes use the file
                     s_nxt.fptr = rc[7] ? 8'(fp + 8'd2) : fp;
                  end
                  CMD_WACC: begin
                     s_nxt.rsp_c = mem[exp_addr(bus.cmd_x)];
                     s_nxt.rsp_b = mem[8'(exp_addr(bus.cmd_x) + 8'd1)];
                     s_nxt.rsp_a = mem[8'(exp_addr(bus.cmd_x) + 8'd2)];
                     we = {3{~bus.cmd_rd}};
                     wa[0] = exp_addr(bus.cmd_x);
                     wa[1] = 8'(exp_addr(bus.cmd_x) + 8'd1);
                     wa[2] = 8'(exp_addr(bus.cmd_x) + 8'd2);
                     wd = {bus.cmd_a, bus.cmd_b, {1'b0, bus.cmd_c[6:0]}};
                  end
                  CMD_SHORT: begin
                     s_nxt.rsp_c = mem[8'({bus.cmd_x, 1'b0})];
                     s_nxt.rsp_b = mem[8'({bus.cmd_x, 1'b1})];
                     s_nxt.rsp_a = 8'h00;
                     we[1:0] = {2{~bus.cmd_rd}};
                     wa[0] = 8'({bus.cmd_x, 1'b0});
                     wa[1] = 8'({bus.cmd_x, 1'b1});
                     wd[0] = bus.cmd_c;
                     wd[1] = bus.cmd_b;
                  end
                  CMD_SLICE: begin
                     s_nxt.gwr = ~bus.cmd_rd;
                     s_nxt.gwr_addr = {bus.cmd_b[6:0], bus.cmd_c};
                     s_nxt.gwr_data = bus.cmd_a;
                  end
                  CMD_WIDEN, CMD_PACK, CMD_LOAD: begin
                     s_nxt.rsp_valid = 1'b0;
                     s_nxt.busy = 1'b1;
                     s_nxt.st = D_ROW;
                     s_nxt.idx = 6'd0;
                     s_nxt.fptr = `TRCAL_FILE_BASE;
                     s_nxt.lat = 4'h0;
                  end
                  default: begin
                  end
               endcase
            end
         end
         D_ROW: begin
            case (s_r.op)
               // One variable code per cycle expanded
               CMD_WIDEN: begin
                  rc = mem[8'(s_r.idx)];
                  rb = rc[7] ? mem[s_r.fptr] : s_r.cur_b;
                  ra = rc[7] ? mem[8'(s_r.fptr + 8'd1)] : s_r.cur_a;
                  // File runs on past 20 longs, at most to 0x77, short of the expanded buffer
                  s_nxt.fptr = rc[7] ? 8'(s_r.fptr + 8'd2) : s_r.fptr;
                  // Accent reverts to base for short codes
                  s_nxt.cur_b = is_acc(rb) ? {`TRCAL_SET_BASE, rb[3:0]}
                                           : rb;
                  s_nxt.cur_a = ra;
                  we = 3'b111;
                  wa[0] = exp_addr(s_r.idx);
                  wa[1] = 8'(exp_addr(s_r.idx) + 8'd1);
                  wa[2] = 8'(exp_addr(s_r.idx) + 8'd2);
                  wd = {ra, rb, {1'b0, rc[6:0]}};
               end
               // Long only where set or attributes change
               CMD_PACK: begin
                  rc = mem[exp_addr(s_r.idx)];
                  rb = mem[8'(exp_addr(s_r.idx) + 8'd1)];
                  ra = mem[8'(exp_addr(s_r.idx) + 8'd2)];
                  lng = (s_r.idx == 6'd0) || (rb != s_r.cur_b) ||
                        (ra != s_r.cur_a);
                  s_nxt.cur_b = is_acc(rb) ? {`TRCAL_SET_BASE, rb[3:0]}
                                           : rb;
                  s_nxt.cur_a = ra;
                  s_nxt.fptr = lng ? 8'(s_r.fptr + 8'd2) : s_r.fptr;
                  we = {lng, lng, 1'b1};
                  wa[0] = 8'(s_r.idx);
                  wa[1] = s_r.fptr;
                  wa[2] = 8'(s_r.fptr + 8'd1);
                  wd = {ra, rb, {lng, rc[6:0]}};
               end
               // Short to long into the internal row buffer
               default: begin
                  rc = mem[8'({s_r.idx, 1'b0})];
                  rb = mem[8'({s_r.idx, 1'b1})];
                  // Latched attributes move only on a space
                  s_nxt.lat = (rc[6:0] == `TRCAL_SPACE_CODE) ? rb[7:4]
                                                            : s_r.lat;
                  ea = rc[7] ? {`TRCAL_SET_MOSAIC, s_nxt.lat}
                             : {`TRCAL_SET_BASE, s_nxt.lat};
                  we = 3'b111;
                  wa[0] = exp_addr(s_r.idx);
                  wa[1] = 8'(exp_addr(s_r.idx) + 8'd1);
                  wa[2] = 8'(exp_addr(s_r.idx) + 8'd2);
                  wd = {{4'h0, rb[3:0]}, ea, {1'b0, rc[6:0]}};
               end
            endcase
            s_nxt.idx = 6'(s_r.idx + 6'd1);
            if (s_r.idx == `TRCAL_LAST_CODE) begin
               s_nxt.st = D_IDLE;
               s_nxt.busy = 1'b0;
               s_nxt.rsp_valid = 1'b1;
            end
         end
         default: s_nxt.st = D_IDLE;
      endcase

      // Slice index from line and double height
      sl = dbl_h_i ? 4'((tv_line_i >> 1) +
                        (dbl_low_i ? `TRCAL_DBL_LOW_OFS : 4'h0))
                   : tv_line_i;
      // Block MSBs from origin per set type
      case (glyph_b_i[7:4])
         `TRCAL_SET_RAM_ALPHA: blk = {set_origin_reg_i[2:0], glyph_b_i[0]};
         `TRCAL_SET_RAM_SEMI, `TRCAL_SET_RAM_STROKE:
            blk = {set_origin_reg_i[5:3], glyph_b_i[0]};
         default: blk = {set_origin_reg_i[7:6], glyph_b_i[1:0]};
      endcase
      // Low-res cell repeats each slice twice
      s_nxt.gaddr = {blk, glyph_c_i[6:0],
                     lores_i ? {1'b0, sl[3:1]} : sl};

      // Underline, flash, conceal, negative, colour, cursor, insert
      fgs = slice_bit_i ||
            ((ul_i || cur_ul_i) && (sl == `TRCAL_LAST_SLICE));
      if (flash_i && (s_r.flash_ph ^ neg_i))
         fgs = 1'b0;
      // Conceal wins over flash and underline
      if (conceal_i)
         fgs = 1'b0;
      f = neg_i ? bg_i : fg_i;
      g = neg_i ? fg_i : bg_i;
      pcol = fgs ? f : g;
      if (cur_cpl_i)
         pcol = ~pcol;
      s_nxt.pix = ins_black_i ? 3'h0 : pcol;
      if (s_r.flash_cnt == 24'(FLASH_HALF - 1)) begin
         s_nxt.flash_cnt = '0;
         s_nxt.flash_ph = ~s_r.flash_ph;
      end else begin
         s_nxt.flash_cnt = 24'(s_r.flash_cnt + 24'd1);
      end

      // Two shift slots in every three clocks
      s_nxt.div3 = (s_r.div3 == `TRCAL_SHIFT_DEN) ? 2'd0
                                                  : 2'(s_r.div3 + 2'd1);
      s_nxt.shift_en = (s_nxt.div3 != `TRCAL_SHIFT_DEN);

      // 12-bit code: C byte and attribute nibble
      // Ten 3x2 sub-windows from A[3:1] and C[6:0]
      mbits = {code80_a_i[3:1], code80_c_i[6:0]};
      midx = 4'({line80_i[3:1], 1'b0} + ((col80_i >= 3'd3) ? 4'd1 : 4'd0));
      s_nxt.m80_fg = code80_c_i[7] && (midx < 4'd10) && mbits[midx];
      s_nxt.m80_mosaic = code80_c_i[7];
      // Alpha glyph and four parallel attributes
      s_nxt.m80_glyph = code80_c_i[6:0];
      s_nxt.m80_attr = code80_c_i[7] ? {3'h0, code80_a_i[0]}
                                     : code80_a_i;
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   always_ff @(posedge sys_clk_i) begin
      for (int k = 0; k < 3; k++) begin
         if (we[k])
            mem[wa[k]] <= wd[k];
      end
   end

   assign bus.busy = s_r.busy;
   assign bus.rsp_valid = s_r.rsp_valid;
   assign bus.rsp_c = s_r.rsp_c;
   assign bus.rsp_b = s_r.rsp_b;
   assign bus.rsp_a = s_r.rsp_a;
   assign glyph_addr_o = s_r.gaddr;
   assign glyph_wr_o = s_r.gwr;
   assign glyph_wr_addr_o = s_r.gwr_addr;
   assign glyph_wr_data_o = s_r.gwr_data;
   assign pixel_o = s_r.pix;
   assign shift_en_o = s_r.shift_en;
   assign m80_fg_o = s_r.m80_fg;
   assign m80_mosaic_o = s_r.m80_mosaic;
   assign m80_glyph_o = s_r.m80_glyph;
   assign m80_attr_o = s_r.m80_attr;
endmodule : trcal_dev

`default_nettype wire

// ===== core/trcal_host.sv
/*
 Host end: turns user requests into single link commands, repeats a code
 for double width, checks glyph numbers and builds slice addresses.
 Assumes the device answers every taken command with rsp_valid.
*/
`timescale 1ns/1ps
`default_nettype none

module trcal_host
   import trcal_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Command link
   trcal_if.hst bus,
   // User request
   input wire logic usr_req_i,
   input wire trcal_op_t usr_op_i,
   input wire logic usr_rd_i,
   input wire logic [5:0] usr_x_i,
   input wire logic [7:0] usr_c_i,
   input wire logic [7:0] usr_b_i,
   input wire logic [7:0] usr_a_i,
   input wire logic usr_dbl_w_i,
   input wire logic [3:0] usr_slice_i,
   input wire logic [3:0] usr_block_i,
   // User answer
   output logic usr_ready_o,
   output logic usr_done_o,
   output logic usr_err_o,
   output logic [7:0] usr_c_o,
   output logic [7:0] usr_b_o,
   output logic [7:0] usr_a_o
);
   trcal_host_t s_r, s_nxt;

   always_comb begin
      logic legal;
      logic [14:0] sa;
      // Glyph numbers 0-3 and 32-127 only
      legal = (usr_c_i[6:0] <= `TRCAL_GLYPH_LOW_MAX) ||
              (usr_c_i[6:0] >= `TRCAL_GLYPH_HIGH_MIN);
      // Block, glyph number and slice form the address
      sa = {usr_block_i, usr_c_i[6:0], usr_slice_i};
      s_nxt = s_r;
      s_nxt.cmd_valid = 1'b0;
      s_nxt.done = 1'b0;
      s_nxt.err = 1'b0;
      case (s_r.st)
         H_IDLE: begin
            s_nxt.ready = 1'b1;
            if (usr_req_i) begin
               s_nxt.ready = 1'b0;
               s_nxt.op = usr_op_i;
               s_nxt.rd = usr_rd_i;
               s_nxt.x = usr_x_i;
               s_nxt.c = usr_c_i;
               s_nxt.b = usr_b_i;
               s_nxt.a = usr_a_i;
               // Double width writes a short or expanded code twice
               s_nxt.again = usr_dbl_w_i && !usr_rd_i &&
                             (usr_op_i == CMD_SHORT ||
                              usr_op_i == CMD_WACC);
               if (usr_op_i == CMD_SLICE) begin
                  s_nxt.c = sa[7:0];
                  s_nxt.b = {1'b0, sa[14:8]};
               end
               if (usr_op_i == CMD_SLICE && !legal) begin
                  s_nxt.err = 1'b1;
                  s_nxt.done = 1'b1;
                  s_nxt.ready = 1'b1;
               end else begin
                  s_nxt.cmd_valid = 1'b1;
                  s_nxt.st = H_WAIT;
               end
            end
         end
         H_WAIT: begin
            if (bus.rsp_valid) begin
               s_nxt.rc = bus.rsp_c;
               s_nxt.rb = bus.rsp_b;
               s_nxt.ra = bus.rsp_a;
               if (s_r.again) begin
                  s_nxt.again = 1'b0;
                  s_nxt.x = 6'(s_r.x + 6'd1);
                  s_nxt.cmd_valid = 1'b1;
               end else begin
                  s_nxt.done = 1'b1;
                  s_nxt.ready = 1'b1;
                  s_nxt.st = H_IDLE;
               end
            end
         end
         default: s_nxt.st = H_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign bus.cmd_valid = s_r.cmd_valid;
   assign bus.cmd_op = s_r.op;
   assign bus.cmd_rd = s_r.rd;
   assign bus.cmd_x = s_r.x;
   assign bus.cmd_c = s_r.c;
   assign bus.cmd_b = s_r.b;
   assign bus.cmd_a = s_r.a;
   assign usr_ready_o = s_r.ready;
   assign usr_done_o = s_r.done;
   assign usr_err_o = s_r.err;
   assign usr_c_o = s_r.rc;
   assign usr_b_o = s_r.rb;
   assign usr_a_o = s_r.ra;
endmodule : trcal_host

`default_nettype wire

// ===== sim/trcal_link_assertions.sv
/*
 Checker of the command link: answer timing and held read data.
 Assumes the signals of one link on one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module trcal_link_chk
   import trcal_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Link
   input wire logic cmd_valid,
   input wire trcal_op_t cmd_op,
   input wire logic cmd_rd,
   input wire logic busy,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_c,
   input wire logic [7:0] rsp_a
);
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);
   logic tk;
   logic row;
   assign tk = cmd_valid && !busy;
   assign row = cmd_op inside {CMD_WIDEN, CMD_PACK, CMD_LOAD};
   sequence s_run; busy [*8] ##32 busy; endsequence
   sequence s_end; !busy && rsp_valid; endsequence
   property p_row; tk && row |=> s_run ##1 s_end; endproperty
   a_row: assert property (p_row) else $error("row op");
   property p_one; tk && !row |=> s_end; endproperty
   a_one: assert property (p_one) else $error("answer");
   property p_pulse; rsp_valid |=> !rsp_valid; endproperty
   a_pulse: assert property (p_pulse) else $error("pulse");
   property p_hold; !rsp_valid |-> $stable(rsp_c) && $stable(rsp_a);
   endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_short; tk && cmd_op == CMD_SHORT && cmd_rd |=> rsp_a == 8'h00;
   endproperty
   a_short: assert property (p_short) else $error("short a");
   property p_wacc; tk && cmd_op == CMD_WACC && cmd_rd |=> !rsp_c[7];
   endproperty
   a_wacc: assert property (p_wacc) else $error("expanded c7");
   property p_gap; rsp_valid |-> !cmd_valid; endproperty
   a_gap: assert property (p_gap) else $error("overlap");
   property p_cause; rsp_valid && !$past(busy) |-> $past(cmd_valid);
   endproperty
   a_cause: assert property (p_cause) else $error("cause");
endmodule : trcal_link_chk

`default_nettype wire

// ===== sim/testbench.sv
/*
 Bench: both ends over the link, user traffic and random render inputs.
 Assumes one 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import trcal_pkg::*;
   logic sys_clk_i = 0;
   logic nrst_i = 0;
   logic req = 0, rd = 0, dw = 0;
   logic [2:0] op = 3'h7, px, ep;
   logic [5:0] x = 0;
   logic [7:0] c = 0, b = 0, a = 0, oc, ob, oa, wd;
   logic [3:0] sl = 0, blk = 0, mat, ls;
   logic rdy, done, err, gw, se, mf, mm, s1, s2, l, fe;
   logic [14:0] ga, wa;
   logic [6:0] mg;
   logic [63:0] rv = 0, pv;
   logic [9:0] mb;
   logic [23:0] mk;
   logic [26:0] q[$], e;
   logic [22:0] wq[$];
   logic [7:0] ec[40], eb[40], ea[40];
   logic lg[40];
   logic [6:0] gl[5] = '{7'h03, 7'h04, 7'h1f, 7'h20, 7'h7f};
   int bad_count = 0, total_checks = 0, pvok = 0, i, n;
   integer seed = 32'h90292d53;
   logic [31:0] r;
   trcal_if lk();
   trcal_host u_trcal_host(.sys_clk_i, .nrst_i, .bus(lk), .usr_req_i(req),
      .usr_op_i(trcal_op_t'(op)), .usr_rd_i(rd), .usr_x_i(x), .usr_c_i(c),
      .usr_b_i(b), .usr_a_i(a), .usr_dbl_w_i(dw), .usr_slice_i(sl),
      .usr_block_i(blk), .usr_ready_o(rdy), .usr_done_o(done),
      .usr_err_o(err), .usr_c_o(oc), .usr_b_o(ob), .usr_a_o(oa));
   trcal_dev #(.FLASH_HALF(8)) u_trcal_dev(.sys_clk_i, .nrst_i, .bus(lk),
      .tv_line_i({rv[61], rv[2:0]}), .dbl_h_i(rv[3]), .dbl_low_i(rv[4]),
      .lores_i(rv[5]), .glyph_c_i(rv[13:6]), .glyph_b_i(rv[21:14]),
      .set_origin_reg_i(rv[29:22]), .glyph_addr_o(ga), .glyph_wr_o(gw),
      .glyph_wr_addr_o(wa), .glyph_wr_data_o(wd), .slice_bit_i(rv[30]),
      .fg_i(rv[33:31]), .bg_i(rv[36:34]), .ul_i(rv[37]), .flash_i(rv[38]),
      .conceal_i(rv[39]), .neg_i(rv[40]), .cur_ul_i(rv[41]),
      .cur_cpl_i(rv[42]), .ins_black_i(rv[43]), .pixel_o(px),
      .shift_en_o(se), .code80_c_i(rv[51:44]), .code80_a_i(rv[55:52]),
      .col80_i({1'b0, rv[57:56]}), .line80_i({1'b0, rv[60:58]}),
      .m80_fg_o(mf), .m80_mosaic_o(mm), .m80_glyph_o(mg), .m80_attr_o(mat));
   trcal_link_chk u_trcal_link_chk(.sys_clk_i, .nrst_i,
      .cmd_valid(lk.cmd_valid), .cmd_op(lk.cmd_op), .cmd_rd(lk.cmd_rd),
      .busy(lk.busy), .rsp_valid(lk.rsp_valid), .rsp_c(lk.rsp_c),
      .rsp_a(lk.rsp_a));
   initial forever #50 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) rv <= {$random(seed), $random(seed)};
   task automatic chk(input logic [24:0] g, input logic [24:0] x,
                      input string m);
      total_checks++;
      if (g !== x) begin
         bad_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   // Waits for ready, notes the answer due, then issues one request
   task automatic go(input logic [2:0] o, input logic w,
      input logic [5:0] xx, input logic [7:0] cc, bb, aa,
      input logic [26:0] ex, input logic d = 0, input logic [3:0] s = 0,
      input logic [3:0] k = 0);
      n = 0;
      @(negedge sys_clk_i);
      while (rdy !== 1'b1 && n < 300) begin
         n++;
         @(negedge sys_clk_i);
      end
      if (n == 300) begin
         chk(1, 0, "ready timeout");
         summarize();
      end
      @(posedge sys_clk_i);
      q.push_back(ex);
      {op, rd, x, c, b, a, dw, sl, blk, req} <=
         {o, w, xx, cc, bb, aa, d, s, k, 1'b1};
      @(posedge sys_clk_i);
      req <= 0;
   endtask : go
   // pk: codes are long only where set or attributes change
   task automatic rdrow(input logic pk);
      for (i = 0; i < 40; i++) begin
         l = pk ? (i == 0 || eb[i] !== {4'h0, eb[i-1][3:0]} ||
                   ea[i] !== ea[i-1]) : lg[i];
         go(CMD_VAR, 1, i[5:0], 0, 0, 0,
            {l, !l, 1'b0, l, ec[i][6:0], eb[i], ea[i]});
      end
   endtask : rdrow
   always @(negedge sys_clk_i) begin
      if (done === 1'b1) begin
         chk(q.size() > 0, 1, "stray done");
         e = q.pop_front();
         mk = e[26] ? 24'hffffff : e[25] ? 24'hff0000 : 24'h0;
         chk({err, {oc, ob, oa} & mk}, {e[24], e[23:0] & mk}, "ans");
      end
      if (gw === 1'b1) chk({wa, wd}, wq.pop_front(), "slice write");
      if (pvok > 2) begin
         mb = {pv[55:53], pv[50:44]};
         chk({mm, mg, mat}, {pv[51:44], pv[51] ? {3'h0, pv[52]} : pv[55:52]},
             "m80");
         if (pv[51]) chk(mf, mb[{pv[60:59], 1'b0} + (pv[57:56] == 2'd3)],
             "mosaic");
         ls = pv[3] ? {1'b0, pv[61], pv[2:1]} + (pv[4] ? 4'h5 : 4'h0)
                    : {pv[61], pv[2:0]};
         if (pv[21:18] == 4'h8 && !pv[5]) chk(ga, {pv[24:22], pv[14],
             pv[12:6], ls}, "glyph");
         // Flash phase is internal: flashing cells only checked concealed or blacked by insert
         fe = (pv[30] || (pv[37] || pv[41]) && ls == 4'h9) && !pv[39];
         ep = (fe ^ pv[40]) ? pv[33:31] : pv[36:34];
         if (pv[42]) ep = ~ep;
         if (pv[43]) chk(px, 0, "insert");
         else if (pv[39] || !pv[38]) chk(px, ep, "render");
         chk({1'b0, se} + s1 + s2, 2, "shift");
      end
      s2 = s1;
      s1 = se;
      pv = rv;
      if (nrst_i) pvok++;
   end
   initial begin
      repeat (5) @(posedge sys_clk_i);
      nrst_i <= 1;
      for (i = 0; i < 40; i++) begin
         r = $random(seed);
         lg[i] = i == 0 || r[7];
         ec[i] = {lg[i], r[6:0]};
         eb[i] = lg[i] ? {1'b0, r[20], 2'h0, r[11:8]} : {4'h0, eb[i-1][3:0]};
         ea[i] = lg[i] ? r[19:12] : ea[i-1];
         go(CMD_VAR, 0, i[5:0], ec[i], eb[i], ea[i], 0);
      end
      rdrow(0);
      go(CMD_WIDEN, 0, 0, 0, 0, 0, 0);
      for (i = 0; i < 40; i++) go(CMD_WACC, 1, i[5:0], 0, 0, 0,
         {3'h4, 1'b0, ec[i][6:0], eb[i], ea[i]});
      go(CMD_PACK, 0, 0, 0, 0, 0, 0);
      rdrow(1);
      r = $random(seed);
      r[6:0] = 7'h20;
      go(CMD_SHORT, 0, 6'd7, r[7:0], r[15:8], 0, 0, 1);
      for (i = 7; i < 9; i++) go(CMD_SHORT, 1, i[5:0], 0, 0, 0,
         {3'h4, r[7:0], r[15:8], 8'h0});
      go(CMD_LOAD, 0, 0, 0, 0, 0, 0);
      go(CMD_WACC, 1, 6'd8, 0, 0, 0, {3'h4, 8'h20, r[7] ? 4'h2 : 4'h0,
         r[15:12], 4'h0, r[11:8]});
      for (i = 0; i < 5; i++) begin
         r = $random(seed);
         l = gl[i] inside {[7'h04:7'h1f]};
         if (!l) wq.push_back({r[3:0], gl[i], r[7:4], r[15:8]});
         go(CMD_SLICE, 0, 0, {1'b0, gl[i]}, 0, r[15:8], {2'h0, l, 24'h0},
            0, r[7:4], r[3:0]);
      end
      go(CMD_NOP, 0, 0, 0, 0, 0, 0);
      repeat (6) @(posedge sys_clk_i);
      chk(q.size() + wq.size(), 0, "missing answers");
      summarize();
   end
endmodule : testbench

`default_nettype wire
